// >>> design/idle_timer_pkg.sv
// Constants, state type and decode table for the idle / standby power timer.
// Assumes a single 100 MHz clock and a command decoder that hands over opcode and count together.
package idle_timer_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 27;

  // Command opcodes recognised as Idle
  localparam logic [7:0] OPC_IDLE_A = 8'hE3;
  localparam logic [7:0] OPC_IDLE_B = 8'h97;

  // Timeout parameter codes and ranges
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [7:0] CODE_LIN_MAX = 8'hF0;
  localparam logic [7:0] CODE_HALF_HR_MAX = 8'hFB;
  localparam logic [7:0] CODE_21MIN = 8'hFC;
  localparam logic [7:0] CODE_8HR = 8'hFD;
  localparam logic [7:0] CODE_RSVD = 8'hFE;
  localparam logic [7:0] CODE_21M15 = 8'hFF;

  // Interval figures, in seconds
  localparam int SECS_W = 15;
  localparam logic [SECS_W-1:0] LIN_STEP_SECS = 15'h0005;
  localparam logic [SECS_W-1:0] HALF_HR_SECS = 15'h0708;
  localparam logic [SECS_W-1:0] SECS_21MIN = 15'h04EC;
  localparam logic [SECS_W-1:0] SECS_8HR = 15'h7080;
  localparam logic [SECS_W-1:0] SECS_21M15 = 15'h04FB;

  // Reset values
  localparam logic [SECS_W-1:0] SECS_RESET = 15'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 27'h0000000;

  // Power states, Gray coded along standby -> spin-up -> idle
  typedef enum logic [1:0]
  {
    ST_STANDBY = 2'b00,
    ST_SPINUP = 2'b01,
    ST_IDLE = 2'b11
  } pwr_state_type;

endpackage

// >>> design/idle_standby_timer.sv
// Power-state controller: Idle command handling, spindle spin-up and auto standby timer.
// Assumes cmd_* and host_access come from logic on clk; spindle_at_speed is an async pin.
module idle_standby_timer
  import idle_timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYCLES_PER_SEC
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_count,
  input wire logic host_access,
  input wire logic spindle_at_speed,
  output logic power_idle_q,
  output logic motor_on_q,
  output logic ready_q,
  output logic timer_on_q,
  output logic cmd_done_q,
  output logic cmd_abort_q,
  output logic err_q
);

  // Decode of the timeout parameter into seconds; zero means disabled
  function automatic logic [SECS_W-1:0] decode_secs(input logic [7:0] code);
    logic [SECS_W-1:0] secs;
    secs = SECS_RESET;
    if (code == CODE_OFF)
      secs = SECS_RESET;
    else if (code <= CODE_LIN_MAX)
      secs = SECS_W'({7'h00, code} * LIN_STEP_SECS);
    else if (code <= CODE_HALF_HR_MAX)
      secs = SECS_W'({7'h00, code - CODE_LIN_MAX} * HALF_HR_SECS);
    else if (code == CODE_21MIN)
      secs = SECS_21MIN;
    else if (code == CODE_8HR)
      secs = SECS_8HR;
    else if (code == CODE_21M15)
      secs = SECS_21M15;
    return secs;
  endfunction

  // Reset synchroniser: async assert, release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Spindle speed pin: two flops before any logic looks at it
  logic speed_meta_q;
  logic speed_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_meta_q <= 1'b0;
      speed_q <= 1'b0;
    end
    else
    begin
      speed_meta_q <= spindle_at_speed;
      speed_q <= speed_meta_q;
    end
  end

  // State and timer registers
  pwr_state_type state_q; // Current power state
  pwr_state_type state_d;
  logic [SECS_W-1:0] interval_q; // Programmed interval, reload value
  logic [SECS_W-1:0] interval_d;
  logic [SECS_W-1:0] sec_left_q; // Seconds still to run
  logic [SECS_W-1:0] sec_left_d;
  logic [PRESC_W-1:0] presc_q; // Clock cycles within the current second
  logic [PRESC_W-1:0] presc_d;
  logic timer_on_d;

  // Command decode
  wire is_idle_opc = (cmd_opcode == OPC_IDLE_A) || (cmd_opcode == OPC_IDLE_B);
  wire idle_cmd = cmd_valid && is_idle_opc;
  wire reject = idle_cmd && (cmd_count == CODE_RSVD);
  wire idle_go = idle_cmd && !reject;
  wire [SECS_W-1:0] new_secs = decode_secs(cmd_count);
  wire new_enable = (cmd_count != CODE_OFF);

  // Timer events; the one-second tick comes from the prescaler
  wire tick = (presc_q == PRESC_W'(TICK_CYCLES - 1));
  wire reload = host_access && timer_on_q && !idle_go;
  wire expire = timer_on_q && tick && (sec_left_q == SECS_W'(1)) && !reload && !idle_go;
  wire in_idle = (state_q != ST_STANDBY);

  // Next-state logic for power state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY:
      begin
        // Idle from Standby enters Idle at once; spin-up skipped if already turning
        if (idle_go)
          state_d = speed_q ? ST_IDLE : ST_SPINUP;
      end
      ST_SPINUP:
      begin
        // Motor is already commanded on; wait for operating speed
        if (expire)
          state_d = ST_STANDBY;
        else if (speed_q)
          state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        // A further Idle command leaves this idle state as it is
        if (expire)
          state_d = ST_STANDBY;
        else
          state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_STANDBY;
      end
    endcase
  end

  // Next values for the timer; access and new command take priority over expiry
  always_comb
  begin
    interval_d = interval_q;
    timer_on_d = timer_on_q;
    sec_left_d = sec_left_q;
    presc_d = tick ? PRESC_RESET : presc_q + PRESC_W'(1);
    if (idle_go)
    begin
      // Load the setting and restart the count from a whole interval
      interval_d = new_secs;
      timer_on_d = new_enable;
      sec_left_d = new_secs;
      presc_d = PRESC_RESET;
    end
    else if (reload)
    begin
      sec_left_d = interval_q;
      presc_d = PRESC_RESET;
    end
    else if (expire)
    begin
      // Timer stays armed with its setting, idle until the next command
      sec_left_d = interval_q;
    end
    else if (timer_on_q && in_idle && tick && (sec_left_q != SECS_RESET))
    begin
      sec_left_d = sec_left_q - SECS_W'(1);
    end
  end

  // State, timer and output registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_STANDBY;
      interval_q <= SECS_RESET;
      sec_left_q <= SECS_RESET;
      presc_q <= PRESC_RESET;
      timer_on_q <= 1'b0;
      power_idle_q <= 1'b0;
      motor_on_q <= 1'b0;
      ready_q <= 1'b0;
      cmd_done_q <= 1'b0;
      cmd_abort_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      interval_q <= interval_d;
      sec_left_q <= sec_left_d;
      presc_q <= presc_d;
      timer_on_q <= timer_on_d;
      power_idle_q <= (state_d != ST_STANDBY);
      motor_on_q <= (state_d != ST_STANDBY);
      ready_q <= (state_d == ST_IDLE);
      cmd_done_q <= idle_go;
      cmd_abort_q <= reject;
      // Error stays up until the next accepted Idle command
      if (reject)
        err_q <= 1'b1;
      else if (idle_go)
        err_q <= 1'b0;
    end
  end

  // Checks of the documented behaviour
  chk_opcode_accept: assert property (@(posedge clk) disable iff (!rst_n)
    idle_go |=> cmd_done_q && !cmd_abort_q)
    else $error("Idle opcode not completed");

  chk_standby_wake: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STANDBY) && idle_go |=> power_idle_q && motor_on_q)
    else $error("Idle from standby did not enter idle");

  chk_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_IDLE) && idle_go |=> (state_q == ST_IDLE))
    else $error("Idle command changed idle state");

  chk_spin_skip: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STANDBY) && idle_go && speed_q |=> ready_q ##1 ready_q)
    else $error("Spin-up not skipped while turning");

  chk_motor_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_IDLE) && !expire |=> motor_on_q && ready_q)
    else $error("Spindle or readiness lost while idle");

  chk_zero_off: assert property (@(posedge clk) disable iff (!rst_n)
    idle_go && (cmd_count == CODE_OFF) |=> !timer_on_q)
    else $error("Zero count left timer enabled");

  chk_interval_load: assert property (@(posedge clk) disable iff (!rst_n)
    idle_go |=> (interval_q == decode_secs($past(cmd_count))) && (sec_left_q == interval_q))
    else $error("Interval not loaded from count");

  chk_code_8hr: assert property (@(posedge clk) disable iff (!rst_n)
    idle_go && (cmd_count == CODE_8HR) |=> (interval_q == SECS_8HR))
    else $error("Code 253 not eight hours");

  chk_expire_standby: assert property (@(posedge clk) disable iff (!rst_n)
    expire |=> !power_idle_q && !motor_on_q)
    else $error("Expiry did not reach standby");

  chk_access_reload: assert property (@(posedge clk) disable iff (!rst_n)
    reload |=> (sec_left_q == interval_q) && (presc_q == PRESC_RESET) && power_idle_q == $past(in_idle))
    else $error("Host access did not reload timer");

  chk_tick_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !idle_go && !reload |=> (presc_q == PRESC_RESET))
    else $error("Prescaler did not wrap on tick");

  chk_reserved_abort: assert property (@(posedge clk) disable iff (!rst_n)
    reject |=> cmd_abort_q && err_q && $stable(interval_q) && $stable(timer_on_q)
      && (state_q == $past(state_q) || $past(expire) || $past(state_q) == ST_SPINUP))
    else $error("Reserved code not rejected cleanly");

endmodule

// >>> sim/host_model.sv
// Host and spindle model: issues commands and accesses, spins the motor.
// Assumes the device samples on the rising edge of clk.
module host_model
#(
  parameter int SPIN_CYCLES = 6
)
(
  input wire logic clk,
  input wire logic motor_on_q,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_count,
  output logic host_access,
  output logic spindle_at_speed
);
  timeunit 1ns;
  timeprecision 100ps;
  int spin_n = 0; // Cycles with motor powered
  initial
  begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_count = 8'h00;
    host_access = 1'b0;
  end
  // Spin-up takes a while, a stopped motor loses speed at once
  always @(posedge clk)
  begin
    spin_n <= motor_on_q ? spin_n + 1 : 0;
  end
  assign spindle_at_speed = spin_n >= SPIN_CYCLES;
  // One command for one cycle; fields scrambled outside it
  task automatic send(input logic [7:0] op, input logic [7:0] cnt);
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_count = cnt;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_opcode = ~op;
    cmd_count = ~cnt;
  endtask
  // One access pulse
  task automatic touch();
    host_access = 1'b1;
    @(posedge clk);
    #1;
    host_access = 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the idle / standby timer.
// Assumes a fast timer tick so that whole intervals fit in the run.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 4; // Clock cycles per timer second
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cv, acc, spd, idle, motor, rdy, ton, done, abrt, err;
  logic [7:0] op, cnt;
  int err_total = 0;
  int n_compared = 0;
  int v;
  always #5 clk = ~clk;
  host_model i_host (.clk(clk), .motor_on_q(motor), .cmd_valid(cv),
    .cmd_opcode(op), .cmd_count(cnt), .host_access(acc), .spindle_at_speed(spd));
  idle_standby_timer #(.TICK_CYCLES(T)) i_dut (.clk(clk), .nrst(nrst),
    .cmd_valid(cv), .cmd_opcode(op), .cmd_count(cnt), .host_access(acc),
    .spindle_at_speed(spd), .power_idle_q(idle), .motor_on_q(motor),
    .ready_q(rdy), .timer_on_q(ton), .cmd_done_q(done), .cmd_abort_q(abrt),
    .err_q(err));
  // Interval in seconds of a count code, zero when disabled
  function automatic int secs(input int c);
    if (c <= 240) return c * 5;
    if (c <= 251) return (c - 240) * 1800;
    if (c == 252) return 1260;
    if (c == 253) return 28800;
    return 1275;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Flag compare
  task automatic chkb(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Cycle count compare
  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Idle command; one quiet cycle first so back-to-back calls never retoggle
  // the command lines in one time step; answer is due right after the taking edge
  task automatic cmd(input logic [7:0] o, input logic [7:0] c);
    tick(1);
    i_host.send(o, c);
    chkb("done", c != 8'hFE, done);
    chkb("abort", c == 8'hFE, abrt);
  endtask
  // Count cycles until the drive drops to standby
  task automatic expire(input int c);
    int n;
    n = 0;
    // Bound sits above the longest interval run here (code 241)
    while (idle === 1'b1 && n < 8000)
    begin
      tick(1);
      n++;
    end
    chkn("expiry", secs(c) * T, n);
    chkb("motor", 1'b0, motor);
    chkb("ready", 1'b0, rdy);
    if (n >= 8000)
      report_and_stop();
  endtask
  initial
  begin
    void'($urandom(43644));
    repeat (12) @(posedge clk);
    chkb("idle", 1'b0, idle);
    chkb("timer", 1'b0, ton);
    #1 nrst = 1'b1;
    tick(2);
    // Access in standby neither wakes nor arms
    i_host.touch();
    chkb("idle", 1'b0, idle);
    // Some other opcode is ignored
    do op_pick: v = $urandom % 256; while (v == 8'hE3 || v == 8'h97);
    i_host.send(v[7:0], 8'h01);
    chkb("done", 1'b0, done);
    cmd(8'hE3, 8'h01);
    chkb("idle", 1'b1, idle);
    chkb("motor", 1'b1, motor);
    chkb("timer", 1'b1, ton);
    expire(1);
    // Let the stopped spindle reach the synchroniser before waking again
    tick(4);
    cmd(8'h97, 8'h00);
    chkb("timer", 1'b0, ton);
    chkb("ready", 1'b0, rdy);
    tick(40);
    chkb("idle", 1'b1, idle);
    chkb("ready", 1'b1, rdy);
    cmd(8'hE3, 8'hFE);
    chkb("err", 1'b1, err);
    chkb("timer", 1'b0, ton);
    cmd(8'h97, 8'h02);
    chkb("err", 1'b0, err);
    chkb("ready", 1'b1, rdy);
    tick(30);
    i_host.touch();
    expire(2);
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 4) ? 1 + $urandom % 240 : (i == 0) ? 240 : (i == 1) ? 241 : (i == 2) ? 252 : 255;
      cmd(i[0] ? 8'h97 : 8'hE3, v[7:0]);
      expire(v);
    end
    cmd(8'hE3, 8'hFD);
    chkb("timer", 1'b1, ton);
    // Eight hours is too long to run out; it must outlast 1300 seconds, longer than codes 1-240, 252 and 255
    tick(5200);
    chkb("idle", 1'b1, idle);
    chkb("ready", 1'b1, rdy);
    report_and_stop();
  end
endmodule
